// >>> logic/setup_ctl.sv
/*
  setup-mode controller: mode machine, label and parameter commit/reload,
  limit-switch behaviour, guard resync, debug level, one-shot overrides.
  Wishbone classic slave on CLK; limit switches and system mode are pins.
  non-volatile storage is modelled by registers preserved over RST.
*/
`timescale 1ns/1ps
`default_nettype none
`include "setup_ctl_cfg.svh"
module setup_ctl (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // wishbone slave
  input  wire setup_ctl_pkg::wb_req_s WB_I,
  output var  setup_ctl_pkg::wb_rsp_s WB_O,
  // system mode pins
  input  wire logic                  SYS_PROGRAMMING_MODE,
  input  wire logic                  SYS_TEST,
  // limit switches and motion status
  input  wire setup_ctl_pkg::limit_s LIMIT_RAW,
  input  wire logic                  MOVING,
  input  wire logic                  MOVE_DIR_UP,
  // motion, limit, override, debug and error outputs
  output logic                       MOVE_START,
  output logic [31:0]                MOVE_TARGET,
  output logic                       MOVE_STOP,
  output setup_ctl_pkg::limit_s      LIMIT_OUT,
  output setup_ctl_pkg::ovr_s        OVR_ACTIVE,
  output logic                       DEBUG_EN,
  output logic                       CMD_ERR
);
  import setup_ctl_pkg::*;

  typedef struct packed {
    board_mode_e mode;
    sw_mode_e    sw;
    limit_s      s1;
    limit_s      s2;
    limit_s      s3;
    limit_s      held;
    ovr_s        ovr;
    logic        ovr_arm;
    logic [31:0] target;
    logic [31:0] label;
    logic [31:0] param;
    logic [31:0] axpos;
    logic [31:0] guard;
    logic [31:0] glimit;
    logic        ack;
    logic [31:0] rdat;
    logic        mstart;
    logic        mstop;
    limit_s      lout;
    logic        err;
    logic [1:0]  err_code;
  } st_s;

  // non-volatile store: untouched by RST
  logic [31:0] nv_label_r;
  logic [31:0] nv_param_r;
  logic [7:0]  nv_debug_r;
  logic [31:0] nv_label_nxt;
  logic [31:0] nv_param_nxt;
  logic [7:0]  nv_debug_nxt;

  st_s st_r;
  st_s st_nxt;

  logic        wr;
  logic        rd;
  logic [3:0]  code;
  logic        setup;
  limit_s      sw;
  logic        mismatch;
  logic        sw_rise;

  assign wr    = WB_I.cyc && WB_I.stb && WB_I.we && !st_r.ack;
  assign rd    = WB_I.cyc && WB_I.stb && !WB_I.we && !st_r.ack;
  assign code  = WB_I.dat[3:0];
  assign setup = (st_r.mode == MODE_SETUP);
  assign sw    = st_r.s2;
  assign mismatch = (MOVE_DIR_UP && sw.low && !sw.high) || (!MOVE_DIR_UP && sw.high && !sw.low);
  // act once per activation, not every cycle the switch stays on
  assign sw_rise  = (sw.low && !st_r.s3.low) || (sw.high && !st_r.s3.high);

  always_comb begin
    st_nxt        = st_r;
    nv_label_nxt  = nv_label_r;
    nv_param_nxt  = nv_param_r;
    nv_debug_nxt  = nv_debug_r;
    st_nxt.s1     = LIMIT_RAW;
    st_nxt.s2     = st_r.s1;
    st_nxt.s3     = st_r.s2;
    st_nxt.ack    = 1'b0;
    st_nxt.mstart = 1'b0;
    st_nxt.mstop  = 1'b0;
    // limit switch behaviour
    if (!setup) begin
      st_nxt.lout = sw;
    end else begin
      case (st_r.sw)
        SW_LATCH: begin
          st_nxt.held = st_r.held | sw;
          st_nxt.lout = st_r.held | sw;
        end
        SW_AUTOSTOP: begin
          st_nxt.lout = sw;
          if (sw_rise && MOVING) begin
            st_nxt.mstop = 1'b1;
            if (mismatch) begin
              st_nxt.param[`F_DIRSENSE] = ~st_r.param[`F_DIRSENSE];
            end
          end
        end
        default: begin
          st_nxt.lout = sw;
        end
      endcase
    end
    if (wr || rd) begin
      st_nxt.ack = 1'b1;
    end
    if (rd) begin
      case (WB_I.adr)
        `A_CTRL:   st_nxt.rdat = {28'h0, st_r.sw, st_r.mode};
        `A_STAT:   st_nxt.rdat = {24'h0, st_r.err_code, st_r.err, st_r.ovr, st_r.ovr_arm, setup};
        `A_TARGET: st_nxt.rdat = st_r.target;
        `A_LABEL:  st_nxt.rdat = st_r.label;
        `A_SLABEL: st_nxt.rdat = nv_label_r;
        `A_PARAM:  st_nxt.rdat = st_r.param;
        `A_VPARAM: st_nxt.rdat = nv_param_r;
        `A_DEBUG:  st_nxt.rdat = {24'h0, nv_debug_r};
        `A_AXPOS:  st_nxt.rdat = st_r.axpos;
        `A_GUARD:  st_nxt.rdat = st_r.guard;
        `A_GLIMIT: st_nxt.rdat = st_r.glimit;
        default:   st_nxt.rdat = 32'h0;
      endcase
    end
    if (wr) begin
      case (WB_I.adr)
        `A_TARGET: st_nxt.target = WB_I.dat;
        `A_LABEL:  st_nxt.label  = WB_I.dat;
        `A_AXPOS:  st_nxt.axpos  = WB_I.dat;
        `A_GLIMIT: st_nxt.glimit = WB_I.dat;
        `A_CMD: begin
          st_nxt.err      = 1'b0;
          st_nxt.err_code = 2'h0;
          // any command consumes a pending override
          if (st_r.ovr_arm) begin
            st_nxt.ovr_arm = 1'b0;
            st_nxt.ovr     = '0;
          end
          case (code)
            `C_ENTER: begin
              if (SYS_PROGRAMMING_MODE || SYS_TEST) begin
                st_nxt.err      = 1'b1;
                st_nxt.err_code = 2'h1;
              end else begin
                st_nxt.mode = MODE_SETUP;
              end
            end
            `C_END, `C_SWSEL, `C_MOVE, `C_PARAM: begin
              if (!setup) begin
                st_nxt.err      = 1'b1;
                st_nxt.err_code = 2'h2;
              end else if (code == `C_END) begin
                st_nxt.mode = MODE_OPERATION_MODE;
                st_nxt.sw   = SW_NORMAL;
                st_nxt.held = '0;
                if (st_r.label != 32'h0) begin
                  nv_label_nxt = st_r.label;
                  nv_param_nxt = st_r.param;
                end else begin
                  st_nxt.param = nv_param_r;
                end
              end else if (code == `C_SWSEL) begin
                if (WB_I.dat[`F_SW_LO+1:`F_SW_LO] == 2'h3) begin
                  st_nxt.err      = 1'b1;
                  st_nxt.err_code = 2'h3;
                end else begin
                  st_nxt.sw   = sw_mode_e'(WB_I.dat[`F_SW_LO+1:`F_SW_LO]);
                  st_nxt.held = '0;
                end
              end else if (code == `C_MOVE) begin
                st_nxt.mstart = 1'b1;
              end else begin
                // low nibble kept, so a same-cycle sense flip survives
                st_nxt.param[31:4] = WB_I.dat[31:4];
              end
            end
            `C_GRPMOVE: begin
              // individual move to a linked member needs the linked override
              if (WB_I.dat[`F_INDIV] && !(st_r.ovr_arm && st_r.ovr.linked)) begin
                st_nxt.err      = 1'b1;
                st_nxt.err_code = 2'h2;
              end else begin
                st_nxt.mstart = 1'b1;
              end
            end
            `C_RESYNC: st_nxt.guard = st_r.axpos;
            `C_DEBUG:  nv_debug_nxt = WB_I.dat[15:8];
            `C_OVR: begin
              st_nxt.ovr_arm     = 1'b1;
              st_nxt.ovr.linked  = WB_I.dat[`F_OVR_ALL] | WB_I.dat[`F_OVR_LNK];
              st_nxt.ovr.guard   = WB_I.dat[`F_OVR_ALL] | WB_I.dat[`F_OVR_GRD];
              st_nxt.ovr.bounded = WB_I.dat[`F_OVR_BND] & ~WB_I.dat[`F_OVR_ALL];
            end
            default: begin
              st_nxt.err      = 1'b1;
              st_nxt.err_code = 2'h3;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    nv_label_r <= nv_label_nxt;
    nv_param_r <= nv_param_nxt;
    nv_debug_r <= nv_debug_nxt;
    if (RST) begin
      st_r          <= '0;
      st_r.mode     <= MODE_OPERATION_MODE;
      st_r.sw       <= SW_NORMAL;
      st_r.glimit   <= 32'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs, all registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_O        <= '0;
      MOVE_START  <= 1'b0;
      MOVE_TARGET <= 32'h0;
      MOVE_STOP   <= 1'b0;
      LIMIT_OUT   <= '0;
      OVR_ACTIVE  <= '0;
      DEBUG_EN    <= 1'b0;
      CMD_ERR     <= 1'b0;
    end else begin
      WB_O.ack    <= st_nxt.ack;
      WB_O.dat    <= st_nxt.rdat;
      MOVE_START  <= st_nxt.mstart;
      MOVE_TARGET <= st_nxt.target;
      MOVE_STOP   <= st_nxt.mstop;
      LIMIT_OUT   <= st_nxt.lout;
      OVR_ACTIVE  <= st_nxt.ovr_arm ? st_nxt.ovr : '0;
      DEBUG_EN    <= (nv_debug_nxt != 8'h0);
      CMD_ERR     <= st_nxt.err;
    end
  end

  a_setup_move: assert property (@(posedge CLK) disable iff (RST) MOVE_START && !$past(st_r.ovr_arm) |-> $past(setup) || $past(WB_I.dat[3:0]) == `C_GRPMOVE)
    else $error("move started outside setup");
  a_enter_refused: assert property (@(posedge CLK) disable iff (RST) wr && WB_I.adr == `A_CMD && code == `C_ENTER && (SYS_PROGRAMMING_MODE || SYS_TEST) && !setup |=> !setup && st_r.err)
    else $error("setup entered during programming_mode or test");
  a_operation_mode_normal: assert property (@(posedge CLK) disable iff (RST) !setup |=> LIMIT_OUT == $past(sw))
    else $error("limit not normal in operation");
  a_latch_hold: assert property (@(posedge CLK) disable iff (RST)
    setup && st_r.sw == SW_LATCH && (st_r.held.low || st_r.held.high) && !wr
    |=> (st_r.held & $past(st_r.held)) == $past(st_r.held))
    else $error("latched switch dropped");
  a_auto_stop: assert property (@(posedge CLK) disable iff (RST)
    setup && st_r.sw == SW_AUTOSTOP && sw_rise && MOVING |=> MOVE_STOP)
    else $error("auto-stop did not stop");
  a_sense_flip: assert property (@(posedge CLK) disable iff (RST)
    setup && st_r.sw == SW_AUTOSTOP && sw_rise && MOVING && mismatch && !wr
    |=> st_r.param[`F_DIRSENSE] != $past(st_r.param[`F_DIRSENSE]))
    else $error("direction sense not inverted");
  a_resync_copy: assert property (@(posedge CLK) disable iff (RST) wr && WB_I.adr == `A_CMD && code == `C_RESYNC |=> st_r.guard == $past(st_r.axpos))
    else $error("guard not resynced");
  a_debug_zero: assert property (@(posedge CLK) disable iff (RST) $past(nv_debug_r) == 8'h0 && nv_debug_r == 8'h0 |-> !DEBUG_EN)
    else $error("debug on at level zero");
  a_all_not_bnd: assert property (@(posedge CLK) disable iff (RST) wr && WB_I.adr == `A_CMD && code == `C_OVR && WB_I.dat[`F_OVR_ALL] |=> st_r.ovr.linked && st_r.ovr.guard && !st_r.ovr.bounded)
    else $error("override-all wrong flags");
  a_ovr_oneshot: assert property (@(posedge CLK) disable iff (RST) st_r.ovr_arm && wr && WB_I.adr == `A_CMD && code != `C_OVR |=> !st_r.ovr_arm)
    else $error("override outlived one command");
  a_reject_state: assert property (@(posedge CLK) disable iff (RST) !setup && wr && WB_I.adr == `A_CMD && code == `C_SWSEL |=> st_r.sw == $past(st_r.sw) && st_r.err)
    else $error("setup command accepted outside setup");
endmodule // setup_ctl
`default_nettype wire

// >>> logic/setup_ctl_cfg.svh
/*
  constants for the setup-mode and limit-switch controller: register offsets,
  field positions, reset values.
  assumes inclusion by bare name from the package and the controller module.
*/
`ifndef SETUP_CTL_CFG_SVH
`define SETUP_CTL_CFG_SVH
`define A_CTRL     8'h00
`define A_STAT     8'h04
`define A_CMD      8'h08
`define A_TARGET   8'h0c
`define A_LABEL    8'h10
`define A_SLABEL   8'h14
`define A_PARAM    8'h18
`define A_VPARAM   8'h1c
`define A_DEBUG    8'h20
`define A_AXPOS    8'h24
`define A_GUARD    8'h28
`define A_GLIMIT   8'h2c
`define A_MOVE     8'h30
// command codes written to A_CMD bits 3:0
`define C_ENTER    4'h1
`define C_END      4'h2
`define C_SWSEL    4'h3
`define C_MOVE     4'h4
`define C_RESYNC   4'h5
`define C_OVR      4'h6
`define C_PARAM    4'h7
`define C_DEBUG    4'h8
`define C_GRPMOVE  4'h9
// command field positions
`define F_SW_LO    4
`define F_OVR_ALL  4
`define F_OVR_LNK  5
`define F_OVR_GRD  6
`define F_OVR_BND  7
`define F_INDIV    8
// param word bit 0 is the motor direction sense
`define F_DIRSENSE 0
`define RST_DEBUG  8'h00
`endif

// >>> logic/setup_ctl_pkg.sv
/*
  types for the setup-mode and limit-switch controller.
  assumes setup_ctl_cfg.svh is on the include path.
*/
`default_nettype none
package setup_ctl_pkg;
  `include "setup_ctl_cfg.svh"
  typedef enum logic [1:0] {SW_NORMAL, SW_LATCH, SW_AUTOSTOP} sw_mode_e;
  typedef enum logic [1:0] {MODE_OPERATION_MODE, MODE_SETUP} board_mode_e;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_s;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;
  typedef struct packed {
    logic        low;
    logic        high;
  } limit_s;
  typedef struct packed {
    logic        linked;
    logic        guard;
    logic        bounded;
  } ovr_s;
endpackage
`default_nettype wire

// >>> testbench/host_model.sv
/*
  host model: issues register requests as the controlling host would.
  assumes one clock shared with the controller and an ack-returning slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "setup_ctl_cfg.svh"
module host_model (
  // clock
  input  wire logic                   CLK,
  // bus
  output var  setup_ctl_pkg::wb_req_s WB_I,
  input  wire setup_ctl_pkg::wb_rsp_s WB_O
);
  import setup_ctl_pkg::*;

  initial WB_I = '0;

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK);
    WB_I <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    // no own limit: only the bench watchdog ends a hung wait
    do begin
      @(posedge CLK);
    end while (WB_O.ack !== 1'b1);
    q = WB_O.dat;
    // released lines show the inverse, not stale values
    WB_I <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~a, dat: ~d};
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // override then the move with nothing in between
  task automatic guarded_move(input logic [31:0] ovr);
    wr(`A_CMD, ovr);
    wr(`A_CMD, {28'h0, `C_MOVE});
  endtask
endmodule // host_model
`default_nettype wire

// >>> testbench/tb_top.sv
/*
  tb_top: self-checking bench for setup_ctl.
  assumes host_model drives the bus; inputs change by nba at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "setup_ctl_cfg.svh"
module tb_top;
  import setup_ctl_pkg::*;
  typedef struct {logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] msk; logic [31:0] exp;} row_s;

  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  wb_req_s     WB_I;
  wb_rsp_s     WB_O;
  logic        SYS_PROGRAMMING_MODE = 1'b0;
  logic        SYS_TEST = 1'b0;
  limit_s      LIMIT_RAW = '0;
  logic        MOVING = 1'b0;
  logic        MOVE_DIR_UP = 1'b0;
  logic        MOVE_START, MOVE_STOP, DEBUG_EN, CMD_ERR;
  logic [31:0] MOVE_TARGET;
  limit_s      LIMIT_OUT;
  ovr_s        OVR_ACTIVE;
  int          err_count = 0;
  int          compares = 0;
  int          starts = 0;
  int          stops = 0;
  int          n0;
  logic [31:0] q, p;

  row_s rows [23] = '{
    '{1'b1, `A_CMD, 32'h308, 32'h0, 32'h0},
    '{1'b0, `A_DEBUG, 32'h0, 32'hff, 32'h3},
    '{1'b1, `A_CMD, 32'h1, 32'h0, 32'h0},
    '{1'b0, `A_CTRL, 32'h0, 32'hf, 32'h1},
    '{1'b1, `A_CMD, 32'h1237, 32'h0, 32'h0},
    '{1'b1, `A_LABEL, 32'h2a, 32'h0, 32'h0},
    '{1'b1, `A_CMD, 32'h2, 32'h0, 32'h0},
    '{1'b0, `A_SLABEL, 32'h0, 32'hffffffff, 32'h2a},
    '{1'b0, `A_VPARAM, 32'h0, 32'hffffffff, 32'h1230},
    '{1'b0, `A_CTRL, 32'h0, 32'h3, 32'h0},
    '{1'b1, `A_CMD, 32'h13, 32'h0, 32'h0},
    '{1'b0, `A_STAT, 32'h0, 32'h20, 32'h20},
    '{1'b0, `A_CTRL, 32'h0, 32'hc, 32'h0},
    '{1'b1, `A_CMD, 32'h1, 32'h0, 32'h0},
    '{1'b1, `A_CMD, 32'h23, 32'h0, 32'h0},
    '{1'b0, `A_CTRL, 32'h0, 32'hf, 32'h9},
    '{1'b1, `A_CMD, 32'h3, 32'h0, 32'h0},
    '{1'b0, `A_CTRL, 32'h0, 32'hf, 32'h1},
    '{1'b1, `A_CMD, 32'h4567, 32'h0, 32'h0},
    '{1'b1, `A_LABEL, 32'h0, 32'h0, 32'h0},
    '{1'b1, `A_CMD, 32'h2, 32'h0, 32'h0},
    '{1'b0, `A_PARAM, 32'h0, 32'hffffffff, 32'h1230},
    '{1'b0, 8'h3c, 32'h0, 32'hffffffff, 32'h0}
  };

  always #20 CLK = ~CLK;

  always @(posedge CLK) begin
    if (MOVE_START === 1'b1) starts++;
    if (MOVE_STOP === 1'b1) stops++;
  end

  setup_ctl u_setup_ctl (.CLK(CLK), .RST(RST), .WB_I(WB_I), .WB_O(WB_O), .SYS_PROGRAMMING_MODE(SYS_PROGRAMMING_MODE),
    .SYS_TEST(SYS_TEST), .LIMIT_RAW(LIMIT_RAW), .MOVING(MOVING), .MOVE_DIR_UP(MOVE_DIR_UP),
    .MOVE_START(MOVE_START), .MOVE_TARGET(MOVE_TARGET), .MOVE_STOP(MOVE_STOP), .LIMIT_OUT(LIMIT_OUT),
    .OVR_ACTIVE(OVR_ACTIVE), .DEBUG_EN(DEBUG_EN), .CMD_ERR(CMD_ERR));

  host_model u_host_model (.CLK(CLK), .WB_I(WB_I), .WB_O(WB_O));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host_model.xfer(1'b0, a, 32'h0, d);
  endtask

  task automatic cmd(input logic [31:0] d);
    u_host_model.wr(`A_CMD, d);
  endtask

  // wait, then step past the edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge CLK);
    err_count++;
    print_verdict;
  end

  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) u_host_model.wr(rows[i].adr, rows[i].dat);
      else begin
        rd(rows[i].adr, q);
        chk("row", q & rows[i].msk, rows[i].exp);
      end
    end
    $display("test rows done");
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK);
      SYS_PROGRAMMING_MODE <= (k == 0);
      SYS_TEST <= (k == 1);
      cmd(32'h1);
      rd(`A_CTRL, q);
      chk("refused mode", q & 32'h3, 32'h0);
      chk("refused err", {31'h0, CMD_ERR}, 32'h1);
    end
    @(posedge CLK);
    SYS_PROGRAMMING_MODE <= 1'b0;
    SYS_TEST <= 1'b0;
    cmd(32'h4447);
    rd(`A_PARAM, q);
    chk("param refused", q, 32'h1230);
    $display("test refused entry done");
    u_host_model.wr(`A_TARGET, 32'hffffe4a8);
    n0 = starts;
    cmd(32'h4);
    wt(4);
    chk("move in operation_mode", 32'(starts - n0), 32'h0);
    cmd(32'h1);
    cmd(32'h4);
    wt(4);
    chk("move in setup", 32'(starts - n0), 32'h1);
    chk("target", MOVE_TARGET, 32'hffffe4a8);
    $display("test gated move done");
    cmd(32'h13);
    @(posedge CLK);
    LIMIT_RAW <= '{low: 1'b0, high: 1'b1};
    wt(4);
    @(posedge CLK);
    LIMIT_RAW <= '0;
    wt(5);
    chk("latched", {31'h0, LIMIT_OUT.high}, 32'h1);
    cmd(32'h2);
    wt(4);
    chk("operation_mode normal", 32'(LIMIT_OUT), 32'h0);
    $display("test latching done");
    cmd(32'h1);
    cmd(32'h23);
    rd(`A_PARAM, p);
    n0 = stops;
    @(posedge CLK);
    MOVING <= 1'b1;
    MOVE_DIR_UP <= 1'b1;
    LIMIT_RAW <= '{low: 1'b1, high: 1'b0};
    wt(6);
    chk("stopped", {31'h0, stops != n0}, 32'h1);
    rd(`A_PARAM, q);
    chk("sense flipped", {31'h0, q[0]}, {31'h0, ~p[0]});
    MOVING <= 1'b0;
    LIMIT_RAW <= '0;
    $display("test autostop done");
    u_host_model.wr(`A_AXPOS, 32'h777);
    cmd(32'h5);
    rd(`A_GUARD, q);
    chk("guard", q, 32'h777);
    cmd(32'h16);
    wt(2);
    chk("ovr all", 32'(OVR_ACTIVE), 32'h6);
    cmd(32'h5);
    wt(2);
    chk("ovr used", 32'(OVR_ACTIVE), 32'h0);
    cmd(32'h86);
    wt(2);
    chk("ovr bounded", 32'(OVR_ACTIVE), 32'h1);
    n0 = starts;
    u_host_model.guarded_move(32'h46);
    wt(4);
    chk("guard move", 32'(starts - n0), 32'h1);
    chk("ovr gone", 32'(OVR_ACTIVE), 32'h0);
    cmd(32'h109);
    chk("linked refused", {31'h0, CMD_ERR}, 32'h1);
    cmd(32'h26);
    cmd(32'h109);
    chk("linked ok", {31'h0, CMD_ERR}, 32'h0);
    $display("test overrides done");
    cmd(32'h8);
    wt(2);
    chk("debug off", {31'h0, DEBUG_EN}, 32'h0);
    cmd(32'h508);
    wt(2);
    chk("debug on", {31'h0, DEBUG_EN}, 32'h1);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(`A_DEBUG, q);
    chk("debug kept", q & 32'hff, 32'h5);
    chk("debug en kept", {31'h0, DEBUG_EN}, 32'h1);
    $display("test debug done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
